//--- src/uec_pkg.sv
package uec_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_EVT_CLR   = 12'h008;
  localparam logic [11:0] OFS_DEV_ADDR  = 12'h00c;
  localparam logic [11:0] OFS_CFG       = 12'h010;
  localparam logic [11:0] OFS_FLAG_VIEW = 12'h034;

  // Values after reset
  localparam logic [31:0] CFG_RST   = 32'h0000_0000;
  localparam logic [6:0]  ADDR_RST  = 7'h00;
  localparam logic [31:0] FLAG_RST  = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Widths and counts
  localparam int ADDR_W = 7;
  localparam int NUM_EP = 6;

  // Configuration field positions
  localparam int CFG_REG_OUT  = 31;
  localparam int CFG_TRX      = 30;
  localparam int CFG_DPPU     = 29;
  localparam int CFG_ENGINE   = 28;
  localparam int CFG_SURGE    = 27;
  localparam int CFG_FLOAT_N  = 26;
  localparam int CFG_RAM      = 25;
  localparam int CFG_DISCH    = 24;
  localparam int CFG_ISO_LSB  = 8;
  localparam int CFG_DIR_LSB  = 0;
  localparam logic [31:0] CFG_MASK = 32'hff00_3f3f;

  // Event flag positions, shared by flags and clear strobes
  localparam int FLG_BUS_RESET = 31;
  localparam int FLG_SUSPEND   = 30;
  localparam int FLG_RESUME    = 29;
  localparam int FLG_SOF       = 26;
  localparam int FLG_WAKE      = 25;
  localparam int FLG_CTRL_LSB  = 19;
  localparam int FLG_BAD_SETUP = 18;
  localparam int FLG_TIMEOUT   = 17;
  localparam int FLG_ACK_LSB   = 8;
  localparam int FLG_NAK_LSB   = 0;

  // Flag groups
  localparam logic [31:0] FLAG_MASK  = 32'he7fe_3f3f;
  localparam logic [31:0] CLEAR_MASK = 32'ha7fe_3f3f;
  localparam logic [31:0] IRQ_MASK   = 32'he6f8_3f3f;
  localparam logic [31:0] BUS_GRP    = 32'ha600_0000;
  localparam logic [31:0] CTRL_GRP   = 32'h01f8_0000;
  localparam logic [31:0] ERR_GRP    = 32'h0006_0000;
  localparam logic [31:0] ACK_GRP    = 32'h0000_3f00;
  localparam logic [31:0] NAK_GRP    = 32'h0000_003f;

endpackage : uec_pkg

//--- src/uec_event_flags.sv
`timescale 1ns/1ps
module uec_event_flags
  import uec_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Set and clear vectors
  input  wire logic [31:0] set_vec,
  input  wire logic [31:0] clr_vec,
  input  wire logic        suspend_det,
  // Flags
  output logic      [31:0] flags
);

  typedef struct packed {
    logic [31:0] flags;
  } uec_flag_st_t;

  uec_flag_st_t st_r;
  uec_flag_st_t st_nxt;

  // Set is ORed after the clear, so a coincident event survives
  always_comb begin
    st_nxt       = st_r;
    st_nxt.flags = ((st_r.flags & ~(clr_vec & CLEAR_MASK)) | set_vec) & FLAG_MASK;
    // Suspend mirrors the bus, software has no say
    st_nxt.flags[FLG_SUSPEND] = suspend_det;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r.flags <= FLAG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flags;

endmodule : uec_event_flags

//--- src/uec_token_filter.sv
`timescale 1ns/1ps
module uec_token_filter
  import uec_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // Configuration
  input  wire logic              engine_on,
  input  wire logic [ADDR_W-1:0] dev_addr,
  input  wire logic [NUM_EP-1:0] iso_sel,
  input  wire logic [NUM_EP-1:0] dir_sel,
  // Decoded token
  input  wire logic              token_valid,
  input  wire logic [ADDR_W-1:0] token_addr,
  input  wire logic [3:0]        token_ep,
  input  wire logic              token_is_out,
  // Verdict
  output logic                   token_accept,
  output logic                   token_iso
);

  typedef struct packed {
    logic accept;
    logic iso;
  } uec_tok_st_t;

  uec_tok_st_t st_r;
  uec_tok_st_t st_nxt;

  // Endpoint zero is bidirectional; one to six follow the direction bit
  always_comb begin
    logic [2:0] idx;
    logic       ep_ok;
    idx        = 3'(token_ep - 4'd1);
    ep_ok      = 1'b0;
    st_nxt     = st_r;
    st_nxt.iso = 1'b0;
    if (token_ep == 4'd0) begin
      ep_ok = 1'b1;
    end else if (token_ep <= 4'(NUM_EP)) begin
      ep_ok      = (dir_sel[idx] == token_is_out);
      st_nxt.iso = iso_sel[idx];
    end
    // A disabled engine answers nothing
    st_nxt.accept = token_valid && engine_on && (token_addr == dev_addr) && ep_ok;
    if (!st_nxt.accept) begin
      st_nxt.iso = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r.accept <= 1'b0;
      st_r.iso    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign token_accept = st_r.accept;
  assign token_iso    = st_r.iso;

endmodule : uec_token_filter

//--- src/uec_top.sv
`timescale 1ns/1ps
// How it works
// - Writing one clears bus reset/resume/frame/wake flags
// - Writing one clears control endpoint completion flags
// - Bits 18/17 clear bad setup, timeout
// - Bits 13..8 clear endpoint ACK flags
// - Bits 5..0 clear endpoint NAK flags
// - Seven-bit address at 0x0C, upper zero
// - Bit 31 picks regulator, else chip supply
// - Transceiver on by bit 30, off in sleep
// - Bit 29 connects the D+ pull-up
// - Bit 28 enables the serial engine
// - Bit 27 enables surge protection
// - Bit 26 low enables float-detect pull-ups
// - Bit 25 enables the packet RAM
// - Bit 24 connects regulator discharge path
// - Bits 13..8 select isochronous endpoint mode
// - Bits 5..0 set endpoint token direction
// - Suspend flag follows bus, no software clear
// - Isochronous completion sets endpoint ACK flag
// - Presetup, bad setup, timeout never interrupt
module uec_top
  import uec_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [31:0]       prdata,
  // Bus events from the engine
  input  wire logic              evt_bus_reset,
  input  wire logic              evt_resume,
  input  wire logic              evt_frame_start,
  input  wire logic              evt_wake,
  input  wire logic              suspend_det,
  input  wire logic [5:0]        evt_ctrl,
  input  wire logic              evt_bad_setup,
  input  wire logic              evt_ack_timeout,
  input  wire logic [NUM_EP-1:0] ep_ack_done,
  input  wire logic [NUM_EP-1:0] ep_iso_done,
  input  wire logic [NUM_EP-1:0] ep_nak_done,
  // Chip power state
  input  wire logic              sleep_mode,
  input  wire logic              deep_sleep_mode,
  input  wire logic              deep_power_down,
  // Decoded token from the receiver
  input  wire logic              token_valid,
  input  wire logic [ADDR_W-1:0] token_addr,
  input  wire logic [3:0]        token_ep,
  input  wire logic              token_is_out,
  // Token verdict
  output logic                   token_accept,
  output logic                   token_iso,
  // Flags and interrupt request
  output logic      [31:0]       event_flags,
  output logic                   usb_irq,
  // Analog and engine controls
  output logic                   regulator_out_enable,
  output logic                   regulator_from_chip_supply,
  output logic                   transceiver_on,
  output logic                   dplus_pullup_on,
  output logic                   serial_engine_enable,
  output logic                   surge_protect_enable,
  output logic                   float_detect_pullup_on,
  output logic                   packet_ram_enable,
  output logic                   regulator_discharge_enable,
  output logic      [NUM_EP-1:0] ep_isochronous_sel,
  output logic      [NUM_EP-1:0] ep_direction_sel,
  output logic      [ADDR_W-1:0] dev_addr_field
);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       cfg;
    logic [31:0]       rdata;
    logic              reg_out;
    logic              trx_on;
    logic              dppu_on;
    logic              engine_on;
    logic              surge_on;
    logic              float_pu_on;
    logic              ram_on;
    logic              disch_on;
  } uec_top_st_t;

  uec_top_st_t st_r;
  uec_top_st_t st_nxt;

  logic [31:0]       set_vec;
  logic [31:0]       clr_vec;
  logic [NUM_EP-1:0] iso_hit;
  logic              setup_ph;
  logic              wr_acc;
  logic              mapped;
  logic              low_power;
  logic [31:0]       set_clr_hit;

  // Bus phase decode
  assign setup_ph  = psel && !penable;
  assign wr_acc    = psel && penable && pwrite;
  assign low_power = sleep_mode || deep_sleep_mode || deep_power_down;

  // Address decode, unmapped offsets answer with an error
  always_comb begin
    if (paddr == OFS_EVT_CLR) begin
      mapped = 1'b1;
    end else if (paddr == OFS_DEV_ADDR) begin
      mapped = 1'b1;
    end else if (paddr == OFS_CFG) begin
      mapped = 1'b1;
    end else if (paddr == OFS_FLAG_VIEW) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // Zero wait states; read data is latched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Clear strobes exist only for the access edge of a full-word write
  assign clr_vec = (wr_acc && paddr == OFS_EVT_CLR && pstrb == 4'hf) ? pwdata : 32'h0000_0000;

  // Isochronous completion counts as ACK only when the mode is selected
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++) begin : g_iso
      assign iso_hit[gi] = ep_iso_done[gi] && st_r.cfg[CFG_ISO_LSB + gi];
    end
  endgenerate

  // Event set vector in flag layout
  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[FLG_BUS_RESET] = evt_bus_reset;
    set_vec[FLG_RESUME]    = evt_resume;
    set_vec[FLG_SOF]       = evt_frame_start;
    set_vec[FLG_WAKE]      = evt_wake;
    set_vec[FLG_CTRL_LSB +: 6]      = evt_ctrl;
    set_vec[FLG_BAD_SETUP]          = evt_bad_setup;
    set_vec[FLG_TIMEOUT]            = evt_ack_timeout;
    set_vec[FLG_ACK_LSB +: NUM_EP]  = ep_ack_done | iso_hit;
    set_vec[FLG_NAK_LSB +: NUM_EP]  = ep_nak_done;
  end

  assign set_clr_hit = set_vec & clr_vec & CLEAR_MASK;

  // Register file and derived controls
  always_comb begin
    st_nxt = st_r;
    if (wr_acc && paddr == OFS_DEV_ADDR && pstrb[0]) begin
      st_nxt.addr = pwdata[ADDR_W-1:0];
    end
    if (wr_acc && paddr == OFS_CFG) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          st_nxt.cfg[b*8 +: 8] = pwdata[b*8 +: 8] & CFG_MASK[b*8 +: 8];
        end
      end
    end
    // Reads return live state; the clear register reads as zero
    if (setup_ph && !pwrite) begin
      if (paddr == OFS_DEV_ADDR) begin
        st_nxt.rdata = {25'h0000000, st_r.addr};
      end else if (paddr == OFS_CFG) begin
        st_nxt.rdata = st_r.cfg;
      end else if (paddr == OFS_FLAG_VIEW) begin
        st_nxt.rdata = event_flags;
      end else begin
        st_nxt.rdata = RDATA_RST;
      end
    end
    // Outputs follow the new value so they settle on the same edge as the write
    st_nxt.reg_out     = st_nxt.cfg[CFG_REG_OUT];
    st_nxt.trx_on      = st_nxt.cfg[CFG_TRX] && !low_power;
    st_nxt.dppu_on     = st_nxt.cfg[CFG_DPPU];
    st_nxt.engine_on   = st_nxt.cfg[CFG_ENGINE];
    st_nxt.surge_on    = st_nxt.cfg[CFG_SURGE];
    st_nxt.float_pu_on = !st_nxt.cfg[CFG_FLOAT_N];
    st_nxt.ram_on      = st_nxt.cfg[CFG_RAM];
    st_nxt.disch_on    = st_nxt.cfg[CFG_DISCH];
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r.addr        <= ADDR_RST;
      st_r.cfg         <= CFG_RST;
      st_r.rdata       <= RDATA_RST;
      st_r.reg_out     <= 1'b0;
      st_r.trx_on      <= 1'b0;
      st_r.dppu_on     <= 1'b0;
      st_r.engine_on   <= 1'b0;
      st_r.surge_on    <= 1'b0;
      st_r.float_pu_on <= 1'b1;
      st_r.ram_on      <= 1'b0;
      st_r.disch_on    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Sticky flags
  uec_event_flags u_flags (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .set_vec     (set_vec),
    .clr_vec     (clr_vec),
    .suspend_det (suspend_det),
    .flags       (event_flags)
  );

  // Token acceptance
  uec_token_filter u_tok (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .engine_on    (st_r.engine_on),
    .dev_addr     (st_r.addr),
    .iso_sel      (st_r.cfg[CFG_ISO_LSB +: NUM_EP]),
    .dir_sel      (st_r.cfg[CFG_DIR_LSB +: NUM_EP]),
    .token_valid  (token_valid),
    .token_addr   (token_addr),
    .token_ep     (token_ep),
    .token_is_out (token_is_out),
    .token_accept (token_accept),
    .token_iso    (token_iso)
  );

  // Status-only flags are masked out of the request
  assign usb_irq = |(event_flags & IRQ_MASK);

  assign prdata                     = st_r.rdata;
  assign regulator_out_enable       = st_r.reg_out;
  assign regulator_from_chip_supply = !st_r.reg_out;
  assign transceiver_on             = st_r.trx_on;
  assign dplus_pullup_on            = st_r.dppu_on;
  assign serial_engine_enable       = st_r.engine_on;
  assign surge_protect_enable       = st_r.surge_on;
  assign float_detect_pullup_on     = st_r.float_pu_on;
  assign packet_ram_enable          = st_r.ram_on;
  assign regulator_discharge_enable = st_r.disch_on;
  assign ep_isochronous_sel         = st_r.cfg[CFG_ISO_LSB +: NUM_EP];
  assign ep_direction_sel           = st_r.cfg[CFG_DIR_LSB +: NUM_EP];
  assign dev_addr_field             = st_r.addr;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic [31:0] clr_only;
  assign clr_only = clr_vec & ~set_vec;

  sequence seq_cfg_write;
    wr_acc && paddr == OFS_CFG && pstrb == 4'hf;
  endsequence

  sequence seq_addr_read;
    setup_ph && !pwrite && paddr == OFS_DEV_ADDR;
  endsequence

  a_bus_evt_clear: assert property (
    ((clr_only & BUS_GRP) != 0) |=> ((event_flags & $past(clr_only) & BUS_GRP) == 0))
    else $error("bus event flag not cleared");

  a_ctrl_evt_clear: assert property (
    ((clr_only & CTRL_GRP) != 0) |=> ((event_flags & $past(clr_only) & CTRL_GRP) == 0))
    else $error("control flag not cleared");

  a_err_flag_clear: assert property (
    ((clr_only & ERR_GRP) != 0) |=> ((event_flags & $past(clr_only) & ERR_GRP) == 0))
    else $error("error flag not cleared");

  a_ack_flag_clear: assert property (
    ((clr_only & ACK_GRP) != 0) |=> ((event_flags & $past(clr_only) & ACK_GRP) == 0))
    else $error("ACK flag not cleared");

  a_nak_flag_clear: assert property (
    ((clr_only & NAK_GRP) != 0) |=> ((event_flags & $past(clr_only) & NAK_GRP) == 0))
    else $error("NAK flag not cleared");

  a_zero_write_keeps: assert property (
    (clr_vec != 0) |=> ((event_flags & ~$past(clr_vec) & $past(event_flags) & CLEAR_MASK)
                      == ($past(event_flags) & ~$past(clr_vec) & CLEAR_MASK)))
    else $error("flag lost on zero write");

  a_set_wins_clear: assert property (
    (set_clr_hit != 0) |=> ((event_flags & $past(set_clr_hit)) == $past(set_clr_hit)))
    else $error("event lost against clear");

  a_suspend_mirror: assert property (
    ##1 event_flags[FLG_SUSPEND] == $past(suspend_det))
    else $error("suspend flag not following bus");

  a_iso_sets_ack: assert property (
    (iso_hit != 0) |=> ((event_flags[FLG_ACK_LSB +: NUM_EP] & $past(iso_hit)) == $past(iso_hit)))
    else $error("isochronous completion missed");

  a_status_no_irq: assert property (
    ((event_flags & ~(ERR_GRP | (32'h1 << (FLG_CTRL_LSB + 5)))) == 0) |-> !usb_irq)
    else $error("status-only flag raised interrupt");

  a_addr_readback: assert property (
    seq_addr_read |=> (prdata[31:7] == 25'h0000000) && (prdata[6:0] == $past(st_r.addr)))
    else $error("address readback wrong");

  a_trx_sleep_off: assert property (
    low_power |=> !transceiver_on)
    else $error("transceiver on in low power");

  a_cfg_polarity: assert property (
    seq_cfg_write |=> (float_detect_pullup_on == !$past(pwdata[CFG_FLOAT_N]))
                   && (dplus_pullup_on == $past(pwdata[CFG_DPPU]))
                   && (regulator_from_chip_supply == !$past(pwdata[CFG_REG_OUT]))
                   && (regulator_discharge_enable == $past(pwdata[CFG_DISCH])))
    else $error("config drive wrong");

  a_foreign_token: assert property (
    (token_valid && token_addr != st_r.addr) |=> !token_accept)
    else $error("foreign address accepted");

  a_engine_off_mute: assert property (
    (token_valid && !st_r.engine_on) |=> !token_accept)
    else $error("token accepted with engine off");

endmodule : uec_top

//--- bench/uec_host_model.sv
`timescale 1ns/1ps
module uec_host_model
  import uec_pkg::*;
(
  // Clock
  input  wire logic              clock,
  // Events, laid out as the flag word
  output logic      [31:0]       ev,
  output logic      [NUM_EP-1:0] iso,
  // Decoded token
  output logic                   tok_v,
  output logic      [ADDR_W-1:0] tok_a,
  output logic      [3:0]        tok_ep,
  output logic                   tok_out
);
  // Quiet bus, token fields scrambled while not valid
  initial begin
    ev      = 32'h0;
    iso     = '0;
    tok_v   = 1'b0;
    tok_a   = 7'h55;
    tok_ep  = 4'ha;
    tok_out = 1'b0;
  end

  // One-cycle event pulse, taken at the second edge
  task automatic pulse(input logic [31:0] v, input logic [NUM_EP-1:0] i);
    @(posedge clock);
    ev  <= v;
    iso <= i;
    @(posedge clock);
    ev  <= 32'h0;
    iso <= '0;
  endtask : pulse

  // Token valid one cycle; fields inverted afterwards so stale values never match
  task automatic token(input logic [ADDR_W-1:0] a, input logic [3:0] e, input logic o);
    @(posedge clock);
    tok_v   <= 1'b1;
    tok_a   <= a;
    tok_ep  <= e;
    tok_out <= o;
    @(posedge clock);
    tok_v   <= 1'b0;
    tok_a   <= ~a;
    tok_ep  <= ~e;
    tok_out <= ~o;
  endtask : token
endmodule : uec_host_model

//--- bench/uec_top_tb.sv
`timescale 1ns/1ps
module uec_top_tb;
  import uec_pkg::*;
  // Token cases: address, endpoint, OUT, accept, iso
  localparam logic [13:0] TC [7] = '{{7'h2a, 4'h1, 3'b110}, {7'h2a, 4'h1, 3'b000},
    {7'h2b, 4'h1, 3'b100}, {7'h2a, 4'h2, 3'b011}, {7'h2a, 4'h2, 3'b100},
    {7'h2a, 4'h0, 3'b110}, {7'h2a, 4'h7, 3'b000}};
  logic              clock, sys_rst, psel, penable, pwrite, pready, pslverr, suspend_det;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, ev, event_flags;
  logic [3:0]        pstrb, tok_ep;
  logic [2:0]        slp;
  logic [NUM_EP-1:0] iso, ep_isochronous_sel, ep_direction_sel;
  logic [ADDR_W-1:0] tok_a, dev_addr_field;
  logic              tok_v, tok_out, token_accept, token_iso, usb_irq;
  logic              regulator_out_enable, regulator_from_chip_supply, transceiver_on;
  logic              dplus_pullup_on, serial_engine_enable, surge_protect_enable;
  logic              float_detect_pullup_on, packet_ram_enable, regulator_discharge_enable;
  int                fail_count, cmp_count, cycles;
  logic [20:0]       drv;

  // All configuration drives in one word
  assign drv = {regulator_out_enable, regulator_from_chip_supply, transceiver_on,
    dplus_pullup_on, serial_engine_enable, surge_protect_enable, float_detect_pullup_on,
    packet_ram_enable, regulator_discharge_enable, ep_isochronous_sel, ep_direction_sel};

  uec_top uut (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .pslverr, .prdata, .evt_bus_reset(ev[31]), .evt_resume(ev[29]),
    .evt_frame_start(ev[26]), .evt_wake(ev[25]), .suspend_det, .evt_ctrl(ev[24:19]),
    .evt_bad_setup(ev[18]), .evt_ack_timeout(ev[17]), .ep_ack_done(ev[13:8]),
    .ep_iso_done(iso), .ep_nak_done(ev[5:0]), .sleep_mode(slp[0]),
    .deep_sleep_mode(slp[1]), .deep_power_down(slp[2]), .token_valid(tok_v),
    .token_addr(tok_a), .token_ep(tok_ep), .token_is_out(tok_out), .token_accept,
    .token_iso, .event_flags, .usb_irq, .regulator_out_enable, .regulator_from_chip_supply,
    .transceiver_on, .dplus_pullup_on, .serial_engine_enable, .surge_protect_enable,
    .float_detect_pullup_on, .packet_ram_enable, .regulator_discharge_enable,
    .ep_isochronous_sel, .ep_direction_sel, .dev_addr_field);

  uec_host_model host (.clock, .ev, .iso, .tok_v, .tok_a, .tok_ep, .tok_out);

  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Watchdog on total run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask : settle

  // One APB transfer; holds everything until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  function automatic logic [20:0] exp_drv(input logic [31:0] c);
    return {c[31], ~c[31], c[30], c[29], c[28], c[27], ~c[26], c[25], c[24], c[13:8], c[5:0]};
  endfunction : exp_drv

  // Reset values, reserved bits, address width, unmapped access
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    logic [31:0] pat [4] = '{32'hffff_ffff, 32'h0, 32'haa00_2a15, 32'h5500_1500};
    apb(1'b0, OFS_CFG, 32'h0, q, e);
    chk("cfg reset", q, CFG_RST);
    chk("drive reset", 32'(drv), 32'(exp_drv(CFG_RST)));
    apb(1'b0, OFS_DEV_ADDR, 32'h0, q, e);
    chk("addr reset", q, 32'h0);
    foreach (pat[k]) begin
      wr(OFS_CFG, pat[k]);
      settle(1);
      chk("drives", 32'(drv), 32'(exp_drv(pat[k])));
      apb(1'b0, OFS_CFG, 32'h0, q, e);
      chk("cfg read", q, pat[k] & CFG_MASK);
    end
    wr(OFS_DEV_ADDR, 32'hffff_ffd5);
    apb(1'b0, OFS_DEV_ADDR, 32'h0, q, e);
    chk("addr read", q, 32'h0000_0055);
    chk("addr field", 32'(dev_addr_field), 32'h55);
    // Byte lane 0 off: address write ignored, cfg keeps its low byte
    pstrb <= 4'he;
    wr(OFS_DEV_ADDR, 32'h0000_0011);
    wr(OFS_CFG, 32'hffff_ffff);
    pstrb <= 4'hf;
    apb(1'b0, OFS_DEV_ADDR, 32'h0, q, e);
    chk("addr strobe", q, 32'h0000_0055);
    apb(1'b0, OFS_CFG, 32'h0, q, e);
    chk("cfg strobe", q, 32'hff00_3f00);
    apb(1'b0, 12'h100, 32'h0, q, e);
    chk("unmapped err", 32'(e), 32'h1);
    apb(1'b0, OFS_EVT_CLR, 32'h0, q, e);
    chk("clear reg read", q, 32'h0);
  endtask : t_regs

  // Each clear strobe clears only its own flag; zero writes do nothing
  task automatic t_clear();
    logic [31:0] q;
    logic        e;
    for (int b = 0; b < 32; b++) begin
      if (CLEAR_MASK[b]) begin
        host.pulse(CLEAR_MASK, '0);
        wr(OFS_EVT_CLR, 32'h0);
        settle(1);
        chk("zero clear", event_flags, CLEAR_MASK);
        wr(OFS_EVT_CLR, 32'h1 << b);
        settle(1);
        chk("one clear", event_flags, CLEAR_MASK & ~(32'h1 << b));
      end
    end
    apb(1'b0, OFS_FLAG_VIEW, 32'h0, q, e);
    chk("flag view", q, CLEAR_MASK & ~32'h8000_0000);
    wr(OFS_EVT_CLR, CLEAR_MASK);
    settle(1);
    chk("all clear", event_flags, 32'h0);
  endtask : t_clear

  // Suspend flag ignores software, follows the bus
  task automatic t_suspend();
    @(posedge clock);
    suspend_det <= 1'b1;
    settle(2);
    chk("suspend set", event_flags, 32'h4000_0000);
    wr(OFS_EVT_CLR, 32'hffff_ffff);
    settle(1);
    chk("suspend kept", event_flags, 32'h4000_0000);
    @(posedge clock);
    suspend_det <= 1'b0;
    settle(2);
    chk("suspend gone", event_flags, 32'h0);
  endtask : t_suspend

  // Status-only flags stay off the request line; set beats a same-cycle clear
  task automatic t_irq_race();
    host.pulse(32'h0106_0000, '0);
    settle(1);
    chk("quiet flags", event_flags, 32'h0106_0000);
    chk("no irq", 32'(usb_irq), 32'h0);
    host.pulse(32'h0400_0000, '0);
    settle(1);
    chk("irq on", 32'(usb_irq), 32'h1);
    wr(OFS_EVT_CLR, CLEAR_MASK);
    fork
      wr(OFS_EVT_CLR, 32'h0400_0000);
      begin
        @(posedge clock);
        host.pulse(32'h0400_0000, '0);
      end
    join
    settle(1);
    chk("set wins", event_flags, 32'h0400_0000);
    wr(OFS_EVT_CLR, CLEAR_MASK);
  endtask : t_irq_race

  // Token filter by address, direction, mode; iso completion counts as ACK
  task automatic t_token();
    wr(OFS_CFG, 32'h1000_0201);
    wr(OFS_DEV_ADDR, 32'h0000_002a);
    foreach (TC[k]) begin
      host.token(TC[k][13:7], TC[k][6:3], TC[k][2]);
      settle(1);
      chk("token verdict", 32'({token_accept, token_iso}), 32'(TC[k][1:0]));
    end
    host.pulse(32'h0, 6'b000011);
    settle(1);
    chk("iso ack", event_flags, 32'h0000_0200);
    wr(OFS_EVT_CLR, CLEAR_MASK);
    wr(OFS_CFG, 32'h0000_0201);
    host.token(7'h2a, 4'h1, 1'b1);
    settle(1);
    chk("engine off", 32'(token_accept), 32'h0);
  endtask : t_token

  // Each low-power state forces the transceiver off
  task automatic t_sleep();
    wr(OFS_CFG, 32'h4000_0000);
    for (int k = 0; k < 3; k++) begin
      @(posedge clock);
      slp <= 3'b001 << k;
      settle(2);
      chk("phy off", 32'(transceiver_on), 32'h0);
      @(posedge clock);
      slp <= 3'b000;
      settle(2);
      chk("phy on", 32'(transceiver_on), 32'h1);
    end
  endtask : t_sleep

  // Main sequence
  initial begin
    {sys_rst, psel, penable, pwrite, suspend_det} = 5'b10000;
    paddr  = 12'h0;
    pwdata = 32'h0;
    pstrb  = 4'hf;
    slp    = 3'b000;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_clear();
    t_suspend();
    t_irq_race();
    t_token();
    t_sleep();
    results();
  end
endmodule : uec_top_tb
